// ==== common/bdrs_pkg.sv ====
// Constants for the background debug register set: offsets, bit
// positions, command field codes, reset values and delay counts.
// Assumes an 8-bit parallel bus with 16-bit addresses.
package bdrs_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] BDRS_MAP_BASE  = 16'hff00;
  localparam logic [15:0] BDRS_A_CMD     = 16'hff00;
  localparam logic [15:0] BDRS_A_STATUS  = 16'hff01;
  localparam logic [15:0] BDRS_A_SHIFT_H = 16'hff02;
  localparam logic [15:0] BDRS_A_SHIFT_L = 16'hff03;
  localparam logic [15:0] BDRS_A_ADDR_H  = 16'hff04;
  localparam logic [15:0] BDRS_A_ADDR_L  = 16'hff05;
  localparam logic [15:0] BDRS_A_CCR     = 16'hff06;

  // ----------------------------------------------------------------
  // Status bit positions and reset values
  // ----------------------------------------------------------------
  localparam int BDRS_S_PERMIT = 7;
  localparam int BDRS_S_ACTIVE = 6;
  localparam int BDRS_S_TAG    = 5;
  localparam int BDRS_S_VALID  = 4;
  localparam int BDRS_S_TRACE  = 3;
  localparam int BDRS_S_CLKSEL = 2;
  localparam logic [7:0] BDRS_STATUS_RST = 8'h00;
  localparam logic [7:0] BDRS_CMD_RST    = 8'h00;

  // ----------------------------------------------------------------
  // Command bit positions and field codes
  // ----------------------------------------------------------------
  localparam int BDRS_C_HF    = 7;
  localparam int BDRS_C_DATA  = 6;
  localparam int BDRS_C_RD    = 5;
  localparam int BDRS_C_ENTER = 4;
  localparam int BDRS_C_WORD  = 3;
  localparam int BDRS_C_MAP   = 2;
  localparam logic [1:0] BDRS_FLOW_GO     = 2'h1;
  localparam logic [1:0] BDRS_FLOW_STEP   = 2'h2;
  localparam logic [1:0] BDRS_FLOW_TAG    = 2'h3;
  localparam logic [2:0] BDRS_TGT_NEXT    = 3'h2;
  localparam logic [2:0] BDRS_TGT_PC      = 3'h3;
  localparam logic [2:0] BDRS_TGT_D       = 3'h4;
  localparam logic [2:0] BDRS_TGT_X       = 3'h5;
  localparam logic [2:0] BDRS_TGT_Y       = 3'h6;
  localparam logic [2:0] BDRS_TGT_SP      = 3'h7;

  // ----------------------------------------------------------------
  // Delay counts in clock cycles; the idle limit counts debug clock ticks (E ticks when the E clock is selected)
  // ----------------------------------------------------------------
  localparam logic [2:0] BDRS_ACT_DELAY  = 3'h4;
  localparam logic [4:0] BDRS_TAG_DELAY  = 5'h10;
  localparam logic [9:0] BDRS_IDLE_LIMIT = 10'h200;
endpackage

// ==== hw/bdrs_register_set.sv ====
// Background debug register set: status flags, command register with
// hardware and firmware decode, shifter, address and saved CCR.
// Assumes the serial engine and CPU share ref_clk and the parallel bus.
`timescale 1ns/100ps
module bdrs_register_set (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        mode_single_chip,
  input  wire logic        mode_periph,
  input  wire logic        debug_pin_in,
  input  wire logic        e_tick,
  input  wire logic        e_slower,
  input  wire logic        cmd_load,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        shift_done,
  input  wire logic [15:0] shift_data,
  input  wire logic        addr_load,
  input  wire logic [15:0] addr_data,
  input  wire logic        enter_req,
  input  wire logic [7:0]  user_ccr,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic [7:0]  bus_wdata,
  output logic [7:0]       bus_rdata_q,
  output logic [7:0]       status_q,
  output logic [7:0]       cmd_q,
  output logic [15:0]      shifter_q,
  output logic [15:0]      address_q,
  output logic [7:0]       ccr_q,
  output logic             debug_map_q,
  output logic             tagging_on_q,
  output logic             clk_sel_q,
  output logic [9:0]       hw_dec_q,
  output logic [2:0]       fw_go_q,
  output logic [5:0]       fw_reg_q,
  output logic             x_inc_q
);
  import bdrs_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchroniser and falling edge detect
  // ----------------------------------------------------------------
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  wire  pin_fall = pin_s3_q & ~pin_s2_q;

  // Third stage only serves the edge detector
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else if (clk_en) begin
      pin_s1_q <= debug_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [2:0] act_cnt_q;
  logic [4:0] tag_cnt_q;
  logic [9:0] idle_q;
  wire active   = status_q[BDRS_S_ACTIVE];
  wire visible  = active | debug_map_q;
  wire hit_cmd  = (bus_addr == BDRS_A_CMD) & (visible | mode_periph);
  wire hit_st   = visible & (bus_addr == BDRS_A_STATUS);
  wire hit_sh   = visible & (bus_addr == BDRS_A_SHIFT_H);
  wire hit_sl   = visible & (bus_addr == BDRS_A_SHIFT_L);
  wire hit_ah   = visible & (bus_addr == BDRS_A_ADDR_H);
  wire hit_al   = visible & (bus_addr == BDRS_A_ADDR_L);
  wire hit_ccr  = visible & (bus_addr == BDRS_A_CCR);
  wire wr_st    = bus_wr & hit_st;
  wire wr_cmd   = bus_wr & hit_cmd;

  // Read mux; address register is read-only, unmapped reads give 0
  logic [7:0] rd_mux;
  always_comb begin
    if (hit_cmd)      rd_mux = cmd_q;
    else if (hit_st)  rd_mux = status_q;
    else if (hit_sh)  rd_mux = shifter_q[15:8];
    else if (hit_sl)  rd_mux = shifter_q[7:0];
    else if (hit_ah)  rd_mux = address_q[15:8];
    else if (hit_al)  rd_mux = address_q[7:0];
    else if (hit_ccr) rd_mux = ccr_q;
    else              rd_mux = 8'h00;
  end

  // ----------------------------------------------------------------
  // Command register and decode
  // ----------------------------------------------------------------
  // Serial loads are dropped while tagging owns the pin
  wire ser_load = cmd_load & ~tagging_on_q;
  wire dbg_tick = clk_sel_q ? e_tick : 1'b1;
  wire idle_out = (idle_q == BDRS_IDLE_LIMIT - 10'h001) & dbg_tick;
  logic [7:0] cmd_d;
  always_comb begin
    if (ser_load)      cmd_d = cmd_byte;
    else if (wr_cmd)   cmd_d = bus_wdata;
    else if (idle_out) cmd_d = BDRS_CMD_RST;
    else               cmd_d = cmd_q;
  end
  wire cmd_new  = ser_load | wr_cmd;
  wire hf_new   = cmd_d[BDRS_C_HF];
  wire hw_enter = ser_load & cmd_byte[BDRS_C_HF] & cmd_byte[BDRS_C_ENTER];
  wire fw_trace = cmd_new & ~hf_new & (cmd_d[4:3] == BDRS_FLOW_STEP);
  // Tag-and-resume raises the tag flag itself and starts the tagging delay
  wire fw_tag   = cmd_new & ~hf_new & (cmd_d[4:3] == BDRS_FLOW_TAG);

  // Idle counter restarts on every host falling edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      idle_q <= 10'h000;
    end else if (clk_en) begin
      if (pin_fall | idle_out) begin
        idle_q <= 10'h000;
      end else if (dbg_tick) begin
        idle_q <= idle_q + 10'h001;
      end
    end
  end

  // Hardware view of the command byte
  logic [9:0] hw_dec_d;
  assign hw_dec_d = {cmd_d[BDRS_C_HF], cmd_d[BDRS_C_DATA], cmd_d[BDRS_C_RD],
                     cmd_d[BDRS_C_ENTER], cmd_d[BDRS_C_WORD], cmd_d[BDRS_C_MAP],
                     cmd_d[1:0] == 2'h0, hf_new & cmd_d[BDRS_C_RD],
                     hf_new & ~cmd_d[BDRS_C_RD], hf_new & cmd_d[BDRS_C_DATA]};
  // Firmware view: go, trace, tag-and-go; then one-hot register target
  logic [2:0] fw_go_d;
  logic [5:0] fw_reg_d;
  assign fw_go_d = hf_new ? 3'h0 :
                   {cmd_d[4:3] == BDRS_FLOW_TAG, cmd_d[4:3] == BDRS_FLOW_STEP,
                    cmd_d[4:3] == BDRS_FLOW_GO};
  assign fw_reg_d = hf_new ? 6'h00 :
                    {cmd_d[2:0] == BDRS_TGT_SP, cmd_d[2:0] == BDRS_TGT_Y,
                     cmd_d[2:0] == BDRS_TGT_X, cmd_d[2:0] == BDRS_TGT_D,
                     cmd_d[2:0] == BDRS_TGT_PC, cmd_d[2:0] == BDRS_TGT_NEXT};
  // Map select only applies to hardware reads and writes
  wire map_d = hf_new & cmd_d[BDRS_C_DATA] & cmd_d[BDRS_C_MAP];

  // Command register and decoded flags move together
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_q       <= BDRS_CMD_RST;
      hw_dec_q    <= 10'h000;
      fw_go_q     <= 3'h0;
      fw_reg_q    <= 6'h00;
      debug_map_q <= 1'b0;
      x_inc_q     <= 1'b0;
    end else if (clk_en) begin
      cmd_q       <= cmd_d;
      hw_dec_q    <= hw_dec_d;
      fw_go_q     <= fw_go_d;
      fw_reg_q    <= fw_reg_d;
      debug_map_q <= map_d;
      x_inc_q     <= cmd_new & fw_reg_d[0];
    end
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  wire hf      = cmd_q[BDRS_C_HF];
  wire entry   = (enter_req | hw_enter) & status_q[BDRS_S_PERMIT] & ~active;
  wire act_clr = wr_st & ~hf & ~bus_wdata[BDRS_S_ACTIVE] & active;
  wire tag_wr  = (wr_st & bus_wdata[BDRS_S_TAG]) | fw_tag;
  logic [7:0] status_d;
  always_comb begin
    status_d = status_q;
    if (wr_st) begin
      status_d[BDRS_S_PERMIT] = bus_wdata[BDRS_S_PERMIT];
      status_d[BDRS_S_TAG]    = bus_wdata[BDRS_S_TAG];
      status_d[BDRS_S_VALID]  = bus_wdata[BDRS_S_VALID];
      status_d[BDRS_S_TRACE]  = bus_wdata[BDRS_S_TRACE];
      if (~hf & bus_wdata[BDRS_S_ACTIVE]) status_d[BDRS_S_ACTIVE] = 1'b1;
      if (hf) status_d[BDRS_S_CLKSEL] = bus_wdata[BDRS_S_CLKSEL];
    end
    if (act_cnt_q == 3'h1) status_d[BDRS_S_ACTIVE] = 1'b0;
    if (cmd_new) status_d[BDRS_S_VALID] = 1'b0;
    // Set events win over clears in the same cycle; entry's tag clear beats the tag-and-resume set
    if (shift_done) status_d[BDRS_S_VALID] = 1'b1;
    if (fw_tag) status_d[BDRS_S_TAG] = 1'b1;
    if (fw_trace) status_d[BDRS_S_TRACE] = 1'b1;
    if (entry) begin
      status_d[BDRS_S_ACTIVE] = 1'b1;
      status_d[BDRS_S_TAG]    = 1'b0;
    end
    status_d[1:0] = 2'h0;
  end

  // Delay counters; entry cancels both pending actions
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_q     <= BDRS_STATUS_RST;
      act_cnt_q    <= 3'h0;
      tag_cnt_q    <= 5'h00;
      tagging_on_q <= 1'b0;
    end else if (clk_en) begin
      status_q <= status_d;
      if (entry) begin
        act_cnt_q <= 3'h0;
      end else if (act_clr) begin
        act_cnt_q <= BDRS_ACT_DELAY;
      end else if (act_cnt_q != 3'h0) begin
        act_cnt_q <= act_cnt_q - 3'h1;
      end
      if (entry | ~status_d[BDRS_S_TAG]) begin
        tag_cnt_q    <= 5'h00;
        tagging_on_q <= 1'b0;
      end else if (tag_wr) begin
        tag_cnt_q <= BDRS_TAG_DELAY;
      end else if (tag_cnt_q != 5'h00) begin
        tag_cnt_q <= tag_cnt_q - 5'h01;
        if (tag_cnt_q == 5'h01) tagging_on_q <= 1'b1;
      end
    end
  end

  // Effective debug clock select, one cycle behind the status bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clk_sel_q <= 1'b0;
    end else if (clk_en) begin
      // A slow E clock overrides the select bit
      clk_sel_q <= e_slower | status_q[BDRS_S_CLKSEL];
    end
  end

  // ----------------------------------------------------------------
  // Data registers and read port
  // ----------------------------------------------------------------
  // Shifter and ccr have no defined reset; they clear to 0 for X-safety
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shifter_q   <= 16'h0000;
      address_q   <= 16'h0000;
      ccr_q       <= 8'h00;
      bus_rdata_q <= 8'h00;
    end else if (clk_en) begin
      if (shift_done) begin
        shifter_q <= shift_data;
      end else if (bus_wr & hit_sh) begin
        shifter_q[15:8] <= bus_wdata;
      end else if (bus_wr & hit_sl) begin
        shifter_q[7:0] <= bus_wdata;
      end
      if (addr_load) address_q <= addr_data;
      if (entry) begin
        ccr_q <= user_ccr;
      end else if (bus_wr & hit_ccr) begin
        ccr_q <= bus_wdata;
      end
      if (bus_rd) bus_rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_act_delay: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    act_clr && !entry ##1 clk_en[*4] |-> status_q[BDRS_S_ACTIVE] ##1 !status_q[BDRS_S_ACTIVE])
    else $error("active flag did not drop four cycles after clear");
  a_entry_perm: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    $rose(status_q[BDRS_S_ACTIVE]) |-> $past(status_q[BDRS_S_PERMIT]) || $past(wr_st))
    else $error("active mode entered without permit");
  a_tag_delay: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    $rose(tagging_on_q) |-> $past(tag_cnt_q) == 5'h01)
    else $error("tagging started at wrong time");
  a_tag_block: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    tagging_on_q && cmd_load && !wr_cmd && !idle_out |=> cmd_q == $past(cmd_q))
    else $error("command taken while tagging");
  a_valid_set: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    shift_done |=> status_q[BDRS_S_VALID] && shifter_q == $past(shift_data))
    else $error("shifter valid not set");
  a_trace_set: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    fw_trace |=> status_q[BDRS_S_TRACE] && fw_go_q[1])
    else $error("trace flag not set");
  a_clk_force: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    e_slower |=> clk_sel_q)
    else $error("slow e clock not forced");
  a_idle_clear: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    idle_out && !cmd_new |=> cmd_q == 8'h00 && idle_q == 10'h000)
    else $error("command not cleared after idle limit");
  a_low_bits: assert property (@(posedge ref_clk) disable iff (reset)
    status_q[1:0] == 2'h0)
    else $error("reserved status bits set");
  a_ccr_save: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    entry |=> ccr_q == $past(user_ccr) && !status_q[BDRS_S_TAG])
    else $error("ccr not saved on entry");

  // Write gating, visibility, decode and read-only checks
  a_permit_gate: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    enter_req && !status_q[BDRS_S_PERMIT] && !active && !wr_st |=> !status_q[BDRS_S_ACTIVE])
    else $error("active mode entered with permit clear");
  a_hide_regs: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    bus_rd && !visible && !mode_periph |=> bus_rdata_q == 8'h00)
    else $error("debug register readable while unmapped");
  a_tag_set: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    fw_tag && !entry |=> status_q[BDRS_S_TAG])
    else $error("tag flag not set by tag-and-resume");
  a_act_write: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    wr_st && hf && !entry && act_cnt_q != 3'h1 |=> status_q[BDRS_S_ACTIVE] == $past(active))
    else $error("active flag written under hardware command");
  a_sel_write: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    wr_st && !hf |=> status_q[BDRS_S_CLKSEL] == $past(status_q[BDRS_S_CLKSEL]))
    else $error("clock select written under firmware command");
  a_addr_ro: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    !addr_load |=> address_q == $past(address_q))
    else $error("address register changed without hardware load");
  a_map_hw: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    cmd_new && !hf_new |=> !debug_map_q)
    else $error("map select honoured for firmware command");
  a_x_next: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
    cmd_new && !hf_new && cmd_d[2:0] == BDRS_TGT_NEXT |=> x_inc_q)
    else $error("next-word command did not request x increment");
endmodule

// ==== bench/bdrs_host_model.sv ====
// Debug host model: sends serial command bytes, pin edges and shift
// completions. Assumes the bench makes ref_clk; pin idles high (pull-up).
`timescale 1ns/100ps
module bdrs_host_model (
  input  wire logic        ref_clk,
  output logic             cmd_load,
  output logic [7:0]       cmd_byte,
  output logic             debug_pin_in,
  output logic             shift_done,
  output logic [15:0]      shift_data
);
  // Idle lines at time zero
  initial begin
    cmd_load     = 1'b0;
    cmd_byte     = 8'h00;
    debug_pin_in = 1'b1;
    shift_done   = 1'b0;
    shift_data   = 16'h0000;
  end

  // One frame: falling edge on the pin and the command byte in the same cycle
  // Never a word write that clears the active flag under firmware
  task automatic send_cmd(input logic [7:0] b);
    @(posedge ref_clk);
    debug_pin_in <= 1'b0;
    cmd_load     <= 1'b1;
    cmd_byte     <= b;
    @(posedge ref_clk);
    debug_pin_in <= 1'b1;
    cmd_load     <= 1'b0;
    cmd_byte     <= ~b;  // Stale byte not left standing
  endtask

  // Bare falling edge, restarts the idle count
  task automatic pin_fall();
    @(posedge ref_clk);
    debug_pin_in <= 1'b0;
    @(posedge ref_clk);
    debug_pin_in <= 1'b1;
  endtask

  // Shift completed with data
  task automatic shift(input logic [15:0] d);
    @(posedge ref_clk);
    shift_done <= 1'b1;
    shift_data <= d;
    @(posedge ref_clk);
    shift_done <= 1'b0;
    shift_data <= ~d;
  endtask

  // Clock-select change: stay at the old rate for 150 cycles
  task automatic settle();
    repeat (150) @(posedge ref_clk);
  endtask
endmodule

// ==== bench/test_bdrs_register_set.sv ====
// Self-checking bench for the debug register set.
// Assumes one 100 MHz clock; the host model stands on the serial side.
`timescale 1ns/100ps
module test_bdrs_register_set;
  import bdrs_pkg::*;
  logic ref_clk, reset, mode_periph, e_tick, e_slower, addr_load, enter_req;
  logic clk_en, mode_single_chip;
  logic bus_rd, bus_wr, cmd_load, debug_pin_in, shift_done, debug_map_q;
  logic tagging_on_q, clk_sel_q, x_inc_q;
  logic [7:0] cmd_byte, user_ccr, bus_wdata, bus_rdata_q, status_q, cmd_q, ccr_q;
  logic [15:0] shift_data, addr_data, bus_addr, shifter_q, address_q;
  logic [9:0] hw_dec_q;
  logic [2:0] fw_go_q;
  logic [5:0] fw_reg_q;
  int failures, cmp_count;

  bdrs_register_set i_bdrs_register_set (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .mode_single_chip(mode_single_chip), .mode_periph(mode_periph), .debug_pin_in(debug_pin_in),
    .e_tick(e_tick), .e_slower(e_slower), .cmd_load(cmd_load), .cmd_byte(cmd_byte),
    .shift_done(shift_done), .shift_data(shift_data), .addr_load(addr_load),
    .addr_data(addr_data), .enter_req(enter_req), .user_ccr(user_ccr),
    .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
    .bus_rdata_q(bus_rdata_q), .status_q(status_q), .cmd_q(cmd_q),
    .shifter_q(shifter_q), .address_q(address_q), .ccr_q(ccr_q),
    .debug_map_q(debug_map_q), .tagging_on_q(tagging_on_q), .clk_sel_q(clk_sel_q),
    .hw_dec_q(hw_dec_q), .fw_go_q(fw_go_q), .fw_reg_q(fw_reg_q), .x_inc_q(x_inc_q));
  bdrs_host_model i_bdrs_host_model (.ref_clk(ref_clk), .cmd_load(cmd_load),
    .cmd_byte(cmd_byte), .debug_pin_in(debug_pin_in), .shift_done(shift_done),
    .shift_data(shift_data));

  // ------------------------------------------------------------
  // Clock, E tick and shared tasks
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) e_tick <= ~e_tick;  // E clock at half rate

  task automatic chk(input string n, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic bwr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
    bus_wdata <= ~d;
  endtask
  // Read data lands one cycle after the strobe
  task automatic brd(input string n, input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 chk(n, 16'(exp), 16'(bus_rdata_q));
  endtask
  task automatic enter(input logic [7:0] c);
    @(posedge ref_clk);
    enter_req <= 1'b1;
    user_ccr  <= c;
    @(posedge ref_clk);
    enter_req <= 1'b0;
    user_ccr  <= ~c;
    #1;
  endtask
  task automatic end_of_test();
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("status", 16'(BDRS_STATUS_RST), 16'(status_q));
    chk("cmd", 16'(BDRS_CMD_RST), 16'(cmd_q));
    enter(8'h11);
    chk("refused", 16'h0000, 16'(status_q[BDRS_S_ACTIVE]));
  endtask
  task automatic t_hw_decode();
    logic [7:0] c[2] = '{8'he8, 8'hc4};
    logic [9:0] d[2] = '{10'h3ad, 10'h31b};
    for (int i = 0; i < 2; i++) begin
      i_bdrs_host_model.send_cmd(c[i]);
      #1 chk("hwdec", 16'(d[i]), 16'(hw_dec_q));
      chk("map", 16'(i), 16'(debug_map_q));
      chk("go", 16'h0000, 16'(fw_go_q));
    end
  endtask
  task automatic t_permit_clock();
    bwr(BDRS_A_STATUS, 8'hc7);
    #1 chk("st", 16'h0084, 16'(status_q));
    @(posedge ref_clk);
    #1 chk("clk", 16'h0001, 16'(clk_sel_q));
    i_bdrs_host_model.settle();
    e_slower <= 1'b1;
    bwr(BDRS_A_STATUS, 8'h80);
    repeat (2) @(posedge ref_clk);
    #1 chk("forced", 16'h0001, 16'(clk_sel_q));
    e_slower <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("bus clk", 16'h0000, 16'(clk_sel_q));
  endtask
  task automatic t_entry();
    enter(8'h5a);
    chk("active", 16'h0001, 16'(status_q[BDRS_S_ACTIVE]));
    brd("ccr", BDRS_A_CCR, 8'h5a);
    chk("ccr_q", 16'h005a, 16'(ccr_q));
    @(posedge ref_clk);
    addr_load <= 1'b1;
    addr_data <= 16'hbe71;
    @(posedge ref_clk);
    addr_load <= 1'b0;
    bwr(BDRS_A_ADDR_H, 8'h00);
    brd("addr", BDRS_A_ADDR_H, 8'hbe);
    chk("addr_q", 16'hbe71, address_q);
    i_bdrs_host_model.shift(16'h1234);
    #1 chk("valid", 16'h0001, 16'(status_q[BDRS_S_VALID]));
    chk("shifter_q", 16'h1234, shifter_q);
    brd("shl", BDRS_A_SHIFT_L, 8'h34);
    i_bdrs_host_model.send_cmd(8'h08);
    #1 chk("valid0", 16'h0000, 16'(status_q[BDRS_S_VALID]));
  endtask
  task automatic t_firmware();
    for (int i = 1; i < 3; i++) begin
      i_bdrs_host_model.send_cmd(8'(i << 3));
      #1 chk("flow", 16'(1 << (i - 1)), 16'(fw_go_q));
    end
    chk("trace", 16'h0001, 16'(status_q[BDRS_S_TRACE]));
    for (int j = 0; j < 8; j++) begin
      i_bdrs_host_model.send_cmd(8'(8'h60 + j));
      #1 chk("target", (j < 2) ? 16'h0000 : 16'(1 << (j - 2)), 16'(fw_reg_q));
      chk("xinc", 16'(j == 2), 16'(x_inc_q));
    end
  endtask
  task automatic t_exit();
    bwr(BDRS_A_STATUS, 8'h80);
    repeat (3) @(posedge ref_clk);
    #1 chk("hold", 16'h0001, 16'(status_q[BDRS_S_ACTIVE]));
    @(posedge ref_clk);
    #1 chk("clear", 16'h0000, 16'(status_q[BDRS_S_ACTIVE]));
    brd("unmapped", BDRS_A_STATUS, 8'h00);
    mode_periph <= 1'b1;
    brd("periph", BDRS_A_CMD, 8'h67);
    mode_periph <= 1'b0;
  endtask
  task automatic t_tagging();
    i_bdrs_host_model.send_cmd(8'h18);
    #1 chk("tag", 16'h0001, 16'(status_q[BDRS_S_TAG]));
    chk("tagresume", 16'h0004, 16'(fw_go_q));
    repeat (15) @(posedge ref_clk);
    #1 chk("early", 16'h0000, 16'(tagging_on_q));
    @(posedge ref_clk);
    #1 chk("tagon", 16'h0001, 16'(tagging_on_q));
    i_bdrs_host_model.send_cmd(8'h64);
    #1 chk("blocked", 16'h0018, 16'(cmd_q));
    enter(8'h00);
    chk("tag0", 16'h0000, 16'({status_q[BDRS_S_TAG], tagging_on_q}));
  endtask
  task automatic t_idle();
    i_bdrs_host_model.send_cmd(8'hc4);
    repeat (400) @(posedge ref_clk);
    i_bdrs_host_model.pin_fall();
    repeat (400) @(posedge ref_clk);
    #1 chk("kept", 16'h00c4, 16'(cmd_q));
    repeat (150) @(posedge ref_clk);
    #1 chk("idle", 16'h0000, 16'(cmd_q));
  endtask
  // Clock enable low: a completed shift must leave no trace
  task automatic t_freeze();
    @(posedge ref_clk);
    clk_en <= 1'b0;
    i_bdrs_host_model.shift(16'hfeed);
    #1 chk("frozen", 16'h1234, shifter_q);
    chk("frozen valid", 16'h0000, 16'(status_q[BDRS_S_VALID]));
    @(posedge ref_clk);
    clk_en <= 1'b1;
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    failures = 0;
    cmp_count = 0;
    {reset, clk_en, mode_single_chip} = 3'h7;
    {mode_periph, e_tick, e_slower, addr_load, enter_req, bus_rd, bus_wr} = 7'h00;
    {user_ccr, bus_wdata} = 16'h0000;
    {addr_data, bus_addr} = 32'h0000_0000;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1 t_reset();
    t_hw_decode();
    t_permit_clock();
    t_entry();
    t_firmware();
    t_exit();
    t_tagging();
    t_idle();
    t_freeze();
    end_of_test();
  end
  // Whole run is about 1200 cycles; allow over sixteen times that
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule
